// ===== design/rxs_pin_sync.sv
// Three-stage synchroniser with agreement filter for the reset pin
module rxs_pin_sync (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic pin_in,
   output logic level_out
);
   logic s1_reg;
   logic s2_reg;
   logic s3_reg;
   wire agree = (s2_reg == s3_reg);

   // Stages start low: the pin must be seen high before any fetch may start
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         s1_reg <= 1'b0;
         s2_reg <= 1'b0;
         s3_reg <= 1'b0;
         level_out <= 1'b0;
      end else begin
         s1_reg <= pin_in;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         if (agree) begin
            level_out <= s2_reg;
         end
      end
   end
endmodule

// ===== design/rxs_pkg.sv
// Constants and carriers shared by the reset and exception sequencer
package rxs_pkg;
   localparam int unsigned CLK_HZ = 50_000_000;
   localparam int unsigned SYNC_STAGES = 3;
   localparam logic [15:0] RESET_VEC_LO_ADDR = 16'h0000;
   localparam logic [15:0] RESET_VEC_HI_ADDR = 16'h0001;
   localparam logic [7:0] CCR_RESET_VAL = 8'h80;
   localparam int unsigned CCR_IMASK_BIT = 7;
   localparam logic [15:0] PC_RESET_VAL = 16'h0000;
   localparam int unsigned RESET_MIN_CYCLES = 10;

   typedef enum logic [5:0] {
      RXS_ST_RESET = 6'h01,
      RXS_ST_INIT  = 6'h02,
      RXS_ST_VEC_HI = 6'h04,
      RXS_ST_VEC_LO = 6'h08,
      RXS_ST_RUN   = 6'h10,
      RXS_ST_IRQ   = 6'h20
   } rxs_state_e;

   typedef struct packed {
      logic req;
      logic [15:0] addr;
   } rxs_mem_req_s;

   typedef struct packed {
      logic valid;
      logic [7:0] data;
   } rxs_mem_rsp_s;
endpackage

// ===== design/rxs_seq.sv
// Reset and interrupt exception sequencer
// How it works
// RL1 - Reset wins over any pending interrupt request at all times.
// RL2 - Reset vector fetch starts right after reset releases, no boundary wait.
// RL3 - Interrupt entry waits for instruction end and no exception in progress.
// RL4 - A low reset pin, once sampled, halts all processing at once.
// RL5 - Source holds reset low at least 10 clocks when running.
// RL6 - At power-up reset stays low until the clock generator settles.
// RL7 - Reset initialises CPU and peripherals, sets mask bit in condition codes.
// RL8 - PC loads from vector at 0000-0001, fetching then starts there.
// RL9 - Reset release is synchronised so the sequence starts on a clock edge.
module rxs_seq
   import rxs_pkg::*;
(
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic ext_reset_n,
   input wire logic irq_req,
   input wire logic insn_done,
   input wire rxs_pkg::rxs_mem_rsp_s mem_rsp,
   output rxs_pkg::rxs_mem_req_s mem_req,
   output logic periph_init,
   output logic cpu_run,
   output logic irq_entry,
   output logic [15:0] pc_out,
   output logic [7:0] cond_code_reg
);
   import rxs_pkg::*;

   rxs_state_e state_reg;
   rxs_state_e state_next;
   logic reset_lvl;
   logic [7:0] vec_hi_reg;

   rxs_pin_sync u_sync (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .pin_in(ext_reset_n),
      .level_out(reset_lvl)
   );

   wire in_reset = !reset_lvl;
   wire rsp_ok = mem_rsp.valid;
   // Interrupt only between instructions in normal running
   wire irq_take = (state_reg == RXS_ST_RUN) && irq_req && insn_done && !in_reset; // [RL3]

   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         RXS_ST_RESET: if (!in_reset) state_next = RXS_ST_INIT; // [RL2] [RL9]
         RXS_ST_INIT: state_next = RXS_ST_VEC_HI;
         RXS_ST_VEC_HI: if (rsp_ok) state_next = RXS_ST_VEC_LO;
         RXS_ST_VEC_LO: if (rsp_ok) state_next = RXS_ST_RUN; // [RL8]
         RXS_ST_RUN: if (irq_take) state_next = RXS_ST_IRQ;
         RXS_ST_IRQ: state_next = RXS_ST_RUN;
         default: state_next = RXS_ST_RESET;
      endcase
      if (in_reset) begin
         state_next = RXS_ST_RESET; // [RL1] [RL4]
      end
   end

   wire [15:0] mem_addr_next = (state_next == RXS_ST_VEC_HI) ? RESET_VEC_LO_ADDR :
                               RESET_VEC_HI_ADDR;
   wire mem_req_next = (state_next == RXS_ST_VEC_HI) || (state_next == RXS_ST_VEC_LO);

   wire nx_reset = (state_next == RXS_ST_RESET);
   wire nx_init = (state_next == RXS_ST_INIT);
   wire nx_run = (state_next == RXS_ST_RUN);
   wire nx_irq = (state_next == RXS_ST_IRQ);
   // A byte only counts when reset is not pulling the sequence back
   wire hi_byte_take = (state_reg == RXS_ST_VEC_HI) && rsp_ok && !in_reset;
   wire lo_byte_take = (state_reg == RXS_ST_VEC_LO) && rsp_ok && !in_reset;

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         state_reg <= RXS_ST_RESET;
      end else begin
         state_reg <= state_next;
      end
   end

   // Request is a level that stands until the memory answers
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         mem_req <= '0;
      end else begin
         mem_req.req <= mem_req_next; // [RL8]
         mem_req.addr <= mem_addr_next;
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         periph_init <= 1'b1;
         cpu_run <= 1'b0;
         irq_entry <= 1'b0;
      end else begin
         periph_init <= nx_reset || nx_init; // [RL7]
         cpu_run <= nx_run;
         irq_entry <= nx_irq; // [RL3]
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         vec_hi_reg <= 8'h00;
      end else if (hi_byte_take) begin
         vec_hi_reg <= mem_rsp.data; // [RL8]
      end
   end

   // Mask bit is only ever forced high here; clearing it is left to the CPU
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         pc_out <= PC_RESET_VAL;
         cond_code_reg <= CCR_RESET_VAL;
      end else if (nx_reset) begin
         pc_out <= PC_RESET_VAL;
         cond_code_reg <= CCR_RESET_VAL; // [RL7]
      end else if (lo_byte_take) begin
         pc_out <= {vec_hi_reg, mem_rsp.data}; // [RL8]
      end
   end

   // Mask bit must read set for the whole reset sequence
   mask_set_a: assert property (@(posedge clk_sys) disable iff (!nrst) // [RL7]
      (state_reg != RXS_ST_RUN && state_reg != RXS_ST_IRQ) |-> cond_code_reg[CCR_IMASK_BIT])
      else $error("mask bit clear during reset sequence");
   reset_halt_a: assert property (@(posedge clk_sys) disable iff (!nrst) // [RL4]
      in_reset |=> (state_reg == RXS_ST_RESET && !cpu_run))
      else $error("processing continued under reset");
   reset_wins_a: assert property (@(posedge clk_sys) disable iff (!nrst) // [RL1]
      (in_reset && irq_req) |=> !irq_entry)
      else $error("interrupt taken under reset");
   release_start_a: assert property (@(posedge clk_sys) disable iff (!nrst) // [RL2]
      (state_reg == RXS_ST_RESET && !in_reset) |=> ##1 (mem_req.req || $past(in_reset)))
      else $error("vector fetch did not start after release");
   irq_boundary_a: assert property (@(posedge clk_sys) disable iff (!nrst) // [RL3]
      $rose(irq_entry) |-> $past(insn_done) && $past(state_reg) == RXS_ST_RUN)
      else $error("interrupt entry off instruction boundary");
   vec_addr_a: assert property (@(posedge clk_sys) disable iff (!nrst) // [RL8]
      (state_reg == RXS_ST_VEC_HI) |-> mem_req.addr == RESET_VEC_LO_ADDR)
      else $error("wrong vector address");
   pc_load_a: assert property (@(posedge clk_sys) disable iff (!nrst) // [RL8]
      (state_reg == RXS_ST_VEC_LO && rsp_ok && !in_reset) |=>
      pc_out == {vec_hi_reg, $past(mem_rsp.data)} && cpu_run)
      else $error("PC not loaded from vector");
   sync_release_a: assert property (@(posedge clk_sys) disable iff (!nrst) // [RL9]
      $rose(reset_lvl) |-> $past(state_reg) == RXS_ST_RESET)
      else $error("release not seen in reset state");

   // Vector fetch order and handshake
   fetch_lo_addr_a: assert property (@(posedge clk_sys) disable iff (!nrst) // [RL8]
      (state_reg == RXS_ST_VEC_LO)
      |-> mem_req.addr == RESET_VEC_HI_ADDR)
      else $error("low vector byte read from wrong address");

   lo_after_hi_a: assert property (@(posedge clk_sys) disable iff (!nrst) // [RL8]
      (state_reg == RXS_ST_VEC_LO)
      |-> $past(state_reg) == RXS_ST_VEC_HI || $past(state_reg) == RXS_ST_VEC_LO)
      else $error("low vector byte fetched before high byte");

   req_in_fetch_a: assert property (@(posedge clk_sys) disable iff (!nrst) // [RL8]
      (state_reg == RXS_ST_VEC_HI || state_reg == RXS_ST_VEC_LO)
      |-> mem_req.req)
      else $error("fetch state without request");

   req_hold_a: assert property (@(posedge clk_sys) disable iff (!nrst) // [RL8]
      (mem_req.req && !rsp_ok && !in_reset)
      |=> mem_req.req && $stable(mem_req.addr))
      else $error("request dropped or moved before answer");

   reset_quiet_a: assert property (@(posedge clk_sys) disable iff (!nrst) // [RL4]
      (state_reg == RXS_ST_RESET)
      |-> !mem_req.req && !cpu_run && !irq_entry)
      else $error("activity while in reset state");

   state_onehot_a: assert property (@(posedge clk_sys) disable iff (!nrst) // [RL4]
      $onehot(state_reg))
      else $error("state code not one-hot");

   init_hold_a: assert property (@(posedge clk_sys) disable iff (!nrst) // [RL7]
      (state_reg == RXS_ST_INIT)
      |-> periph_init && !cpu_run)
      else $error("init state without init hold");

   release_step_a: assert property (@(posedge clk_sys) disable iff (!nrst) // [RL2]
      (state_reg == RXS_ST_RESET && !in_reset)
      |=> state_reg == RXS_ST_INIT)
      else $error("release did not start the sequence at once");

   init_step_a: assert property (@(posedge clk_sys) disable iff (!nrst) // [RL2]
      (state_reg == RXS_ST_INIT)
      |=> state_reg == RXS_ST_VEC_HI || $past(in_reset))
      else $error("init not followed by vector fetch");

   run_no_init_a: assert property (@(posedge clk_sys) disable iff (!nrst) // [RL7]
      cpu_run
      |-> !periph_init)
      else $error("running while init held");

   ccr_reset_a: assert property (@(posedge clk_sys) disable iff (!nrst) // [RL7]
      (state_reg == RXS_ST_RESET)
      |-> cond_code_reg == CCR_RESET_VAL)
      else $error("condition codes not at reset value");

   pc_reset_a: assert property (@(posedge clk_sys) disable iff (!nrst) // [RL8]
      (state_reg == RXS_ST_RESET)
      |-> pc_out == PC_RESET_VAL)
      else $error("program counter not cleared in reset");

   pc_hold_a: assert property (@(posedge clk_sys) disable iff (!nrst) // [RL8]
      (state_reg == RXS_ST_RUN && !in_reset)
      |=> $stable(pc_out))
      else $error("program counter moved while running");

   irq_pulse_a: assert property (@(posedge clk_sys) disable iff (!nrst) // [RL3]
      irq_entry
      |=> !irq_entry)
      else $error("interrupt entry longer than one cycle");

   irq_run_only_a: assert property (@(posedge clk_sys) disable iff (!nrst) // [RL3]
      (state_reg != RXS_ST_RUN)
      |=> !irq_entry)
      else $error("interrupt entry during exception processing");

   irq_no_done_a: assert property (@(posedge clk_sys) disable iff (!nrst) // [RL3]
      !insn_done
      |=> !irq_entry)
      else $error("interrupt entry without instruction end");
endmodule

// ===== tb/reset_exception_sequencer_tb.sv
// Self-checking bench for the reset and exception sequencer
module reset_exception_sequencer_tb import rxs_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys, nrst, ext_reset_n, irq_req, insn_done, periph_init, cpu_run, irq_entry;
   logic [15:0] pc_out, vec_val;
   logic [7:0] cond_code_reg;
   logic [1:0] lat;
   rxs_mem_req_s mem_req;
   rxs_mem_rsp_s mem_rsp;
   int errors = 0, n_tests = 0, cyc = 0, k;
   rxs_seq rxs_seq_inst (.clk_sys(clk_sys), .nrst(nrst), .ext_reset_n(ext_reset_n),
      .irq_req(irq_req), .insn_done(insn_done), .mem_rsp(mem_rsp), .mem_req(mem_req),
      .periph_init(periph_init), .cpu_run(cpu_run), .irq_entry(irq_entry),
      .pc_out(pc_out), .cond_code_reg(cond_code_reg));
   rxs_vec_mem rxs_vec_mem_inst (.clk_sys(clk_sys), .vec_val(vec_val), .lat(lat),
      .mem_req(mem_req), .mem_rsp(mem_rsp));
   function automatic logic [15:0] vec_word(input logic [15:0] v);
      return {v[15:8], v[7:0]};
   endfunction
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic give_verdict;
      $display("tests %0d errors %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         errors++;
         give_verdict();
      end
   end
   initial begin
      nrst = 1'b0;
      ext_reset_n = 1'b0;
      irq_req = 1'b0;
      insn_done = 1'b0;
      vec_val = 16'h0000;
      lat = 2'h0;
      k = $urandom(5);
      repeat (8) @(posedge clk_sys);
      nrst <= 1'b1;
      for (int i = 0; i < 6; i++) begin
         @(posedge clk_sys);
         vec_val <= (i == 0) ? 16'hFFFF : 16'($urandom());
         lat <= 2'($urandom_range(2));
         irq_req <= 1'b1;
         insn_done <= 1'b1;
         ext_reset_n <= 1'b0;
         repeat (10 + i) @(posedge clk_sys);
         #1 chk("init", 1'b1, periph_init);
         chk("run", 1'b0, cpu_run);
         chk("ccr", CCR_RESET_VAL, cond_code_reg);
         chk("irq under reset", 1'b0, irq_entry);
         @(posedge clk_sys);
         ext_reset_n <= 1'b1;
         insn_done <= 1'b0;
         k = 0;
         while (cpu_run !== 1'b1 && k < 30) begin
            @(posedge clk_sys);
            #1 k++;
            chk("irq in reset", 1'b0, irq_entry);
         end
         chk("run", 1'b1, cpu_run);
         chk("pc", vec_word(vec_val), pc_out);
         repeat (3) @(posedge clk_sys);
         #1 chk("irq early", 1'b0, irq_entry);
         @(posedge clk_sys);
         insn_done <= 1'b1;
         @(posedge clk_sys);
         insn_done <= 1'b0;
         irq_req <= 1'b0;
         k = 0;
         repeat (3) begin
            #1 if (irq_entry === 1'b1) k = 1;
            @(posedge clk_sys);
         end
         chk("irq entry", 1'b1, 16'(k));
      end
      give_verdict();
   end
endmodule

// ===== tb/rxs_vec_mem.sv
// Vector memory that answers the sequencer's fetch requests
module rxs_vec_mem
   import rxs_pkg::*;
(
   input wire logic clk_sys,
   input wire logic [15:0] vec_val,
   input wire logic [1:0] lat,
   input wire rxs_pkg::rxs_mem_req_s mem_req,
   output rxs_pkg::rxs_mem_rsp_s mem_rsp
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] wait_reg = 2'h0;
   initial mem_rsp = '0;
   always @(posedge clk_sys) begin
      mem_rsp.valid <= 1'b0;
      // Junk data between answers so a stale byte is never read as good
      mem_rsp.data <= ~mem_rsp.data;
      if (mem_req.req && !mem_rsp.valid) begin
         if (wait_reg == lat) begin
            wait_reg <= 2'h0;
            mem_rsp.valid <= 1'b1;
            mem_rsp.data <= mem_req.addr[0] ? vec_val[7:0] : vec_val[15:8];
         end else begin
            wait_reg <= wait_reg + 2'h1;
         end
      end
   end
endmodule
